// ==== rtl/acms_seq.sv ====
`timescale 1ns/100ps
`include "acms_cfg.svh"
// What this block does
// - Measure, wake-up and standby modes exist
// - Output rate selectable from 12.5 to 400 Hz
// - Wake-up mode samples about six times per second
// - Wake motion: auto-measure, interrupt and wake output
// - Wake-up keeps all but the activity timer
// - Standby keeps flags, raises no new interrupts
// - Comes up in standby, sensing off
// - Ranges two, four, eight g; twelve-bit weight
// - Filter pole quarter or half of rate
// - Second event pin doubles as sync trigger
// - First event pin doubles as sample clock
// - Data in on MOSI, out on MISO
// - Filter pole defaults to quarter rate
module acms_seq #(
	parameter int P_RATE_BASE_CYC = `ACMS_RATE_BASE_CYC,
	parameter int P_WAKE_CYC = `ACMS_WAKE_CYC
) (
	// System clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Serial link from the host
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe_n,
	// Event pin A, also external sample clock
	input wire logic i_event_out_a_ext_clock_in,
	output logic o_event_out_a_ext_clock_in_drv,
	output logic o_event_out_a_ext_clock_in_oe_n,
	// Event pin B, also sync trigger
	input wire logic i_event_out_b_sync_trigger_in,
	output logic o_event_out_b_sync_trigger_in_drv,
	output logic o_event_out_b_sync_trigger_in_oe_n,
	// Sensing core
	input wire logic i_motion_detected,
	output logic o_sample_strobe,
	output logic [1:0] o_mode,
	output logic o_data_path_en,
	output logic o_activity_timer_en,
	output logic [1:0] o_range,
	output logic [3:0] o_lsb_weight_mg,
	output logic [2:0] o_output_sample_rate,
	output logic o_filter_pole_half_rate_sel,
	output logic [2:0] o_filter_pole_div,
	output logic o_awake
);
	// Link domain
	logic [3:0] bit_cnt;
	logic [14:0] rx;
	logic [7:0] tx;
	logic [6:0] lk_addr;
	logic [7:0] lk_data;
	logic lk_wr_tgl;
	logic [7:0] rd_byte;

	// System domain
	acms_pkg::acms_mode_t mode;
	acms_pkg::acms_mode_t next_mode;
	logic [2:0] sy;
	logic wr_seen;
	logic wr_pulse;
	logic wr_mode;
	logic wr_cfg;
	logic wr_wake;
	logic wr_status;
	logic [2:0] rate_code;
	logic [2:0] rate_eff;
	logic pole_half;
	logic [1:0] range;
	logic ext_clk_en;
	logic ext_trig_en;
	logic auto_measure;
	logic int_en;
	logic awake_en;
	logic evt_flag;
	logic awake;
	logic pin_a_prev;
	logic pin_b_prev;
	logic clk_edge;
	logic trig_edge;
	logic [22:0] rate_cnt;
	logic [22:0] rate_limit;
	logic [22:0] wake_cnt;
	logic rate_tick;
	logic wake_tick;
	logic sample_now;
	logic motion_hit;
	logic wake_hit;
	logic flag_clr;
	logic awake_clr;

	// ---------------- Link side, clocked by the host's SCLK ----------------
	// Frame: write bit, 7 address bits, 8 data bits; CS high clears the frame
	always_ff @(posedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			bit_cnt <= 4'h0;
			rx <= 15'h0000;
			tx <= 8'h00;
		end else begin
			rx <= {rx[13:0], i_mosi};
			bit_cnt <= bit_cnt + 4'h1;
			if (bit_cnt == 4'h7) begin
				tx <= rd_byte;
			end else begin
				tx <= {tx[6:0], 1'b0};
			end
		end
	end

	// Config values change only on host writes, so they are steady while read here;
	// mode and status may move mid-read and then show old or new per bit, so old and new bits can mix
	always_comb begin
		rd_byte = 8'h00;
		unique case ({rx[5:0], i_mosi})
			`ACMS_ADDR_MODE: rd_byte = {6'h00, mode};
			`ACMS_ADDR_CFG: rd_byte = {ext_trig_en, ext_clk_en, range, pole_half, rate_code};
			`ACMS_ADDR_WAKE: rd_byte = {5'h00, awake_en, int_en, auto_measure};
			`ACMS_ADDR_STATUS: rd_byte = {4'h0, awake, evt_flag, mode};
			default: rd_byte = 8'h00;
		endcase
	end

	// Write held until the next write frame's last bit; only a completed frame counts
	always_ff @(posedge i_sclk or posedge i_reset) begin
		if (i_reset) begin
			lk_addr <= 7'h00;
			lk_data <= 8'h00;
			lk_wr_tgl <= 1'b0;
		end else if (bit_cnt == 4'hF && rx[14]) begin
			lk_addr <= rx[13:7];
			lk_data <= {rx[6:0], i_mosi};
			lk_wr_tgl <= ~lk_wr_tgl;
		end
	end

	always_ff @(negedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			o_miso <= 1'b0;
		end else begin
			o_miso <= tx[7];
		end
	end

	assign o_miso_oe_n = i_cs_n;

	// ---------------- Crossing into the system clock ----------------
	acms_sync #(
		.W(3)
	) u_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_d({lk_wr_tgl, i_event_out_b_sync_trigger_in, i_event_out_a_ext_clock_in}),
		.o_q(sy)
	);

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wr_seen <= 1'b0;
			pin_a_prev <= 1'b0;
			pin_b_prev <= 1'b0;
		end else begin
			wr_seen <= sy[2];
			pin_a_prev <= sy[0];
			pin_b_prev <= sy[1];
		end
	end

	// Address and data are stable long before the toggle is seen here
	assign wr_pulse = sy[2] ^ wr_seen;
	assign wr_mode = wr_pulse && (lk_addr == `ACMS_ADDR_MODE);
	assign wr_cfg = wr_pulse && (lk_addr == `ACMS_ADDR_CFG);
	assign wr_wake = wr_pulse && (lk_addr == `ACMS_ADDR_WAKE);
	assign wr_status = wr_pulse && (lk_addr == `ACMS_ADDR_STATUS);
	assign flag_clr = wr_status && lk_data[`ACMS_EVT_BIT];
	assign awake_clr = wr_status && lk_data[`ACMS_AWAKE_BIT];
	assign clk_edge = sy[0] && !pin_a_prev;
	assign trig_edge = sy[1] && !pin_b_prev;

	// ---------------- Operating mode ----------------
	always_comb begin
		unique case (lk_data[`ACMS_MODE_MSB:`ACMS_MODE_LSB])
			2'b00: next_mode = acms_pkg::ACMS_STBY;
			2'b01: next_mode = acms_pkg::ACMS_WAKE;
			2'b10: next_mode = acms_pkg::ACMS_MEAS;
			2'b11: next_mode = acms_pkg::ACMS_STBY;
		endcase
	end

	// Host write beats autonomous wake in the same cycle: latest intent wins
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			mode <= acms_pkg::ACMS_STBY;
		end else if (wr_mode) begin
			mode <= next_mode;
		end else if (wake_hit && auto_measure) begin
			mode <= acms_pkg::ACMS_MEAS;
		end
	end

	// ---------------- Configuration ----------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rate_code <= `ACMS_RATE_RST;
			pole_half <= `ACMS_HALF_RST;
			range <= `ACMS_RANGE_RST;
			ext_clk_en <= 1'b0;
			ext_trig_en <= 1'b0;
		end else if (wr_cfg) begin
			rate_code <= lk_data[`ACMS_RATE_MSB:`ACMS_RATE_LSB];
			pole_half <= lk_data[`ACMS_HALF_BIT];
			range <= lk_data[`ACMS_RANGE_MSB:`ACMS_RANGE_LSB];
			ext_clk_en <= lk_data[`ACMS_EXTCLK_BIT];
			ext_trig_en <= lk_data[`ACMS_EXTTRIG_BIT];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			{awake_en, int_en, auto_measure} <= `ACMS_WAKE_RST;
		end else if (wr_wake) begin
			auto_measure <= lk_data[`ACMS_AUTO_BIT];
			int_en <= lk_data[`ACMS_INTEN_BIT];
			awake_en <= lk_data[`ACMS_AWEN_BIT];
		end
	end

	// ---------------- Sample timing ----------------
	// Codes above 400 Hz clamp to 400 Hz
	assign rate_eff = (rate_code > `ACMS_RATE_MAX) ? `ACMS_RATE_MAX : rate_code;
	assign rate_limit = 23'(P_RATE_BASE_CYC) >> rate_eff;
	assign rate_tick = (mode == acms_pkg::ACMS_MEAS) && (rate_cnt >= rate_limit - 23'h000001);
	assign wake_tick = (mode == acms_pkg::ACMS_WAKE) && (wake_cnt >= 23'(P_WAKE_CYC) - 23'h000001);

	always_ff @(posedge i_clk) begin
		if (i_reset || mode != acms_pkg::ACMS_MEAS || rate_tick) begin
			rate_cnt <= 23'h000000;
		end else begin
			rate_cnt <= rate_cnt + 23'h000001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset || mode != acms_pkg::ACMS_WAKE || wake_tick) begin
			wake_cnt <= 23'h000000;
		end else begin
			wake_cnt <= wake_cnt + 23'h000001;
		end
	end

	always_comb begin
		sample_now = 1'b0;
		unique case (mode)
			acms_pkg::ACMS_MEAS: begin
				if (ext_trig_en) begin
					sample_now = trig_edge;
				end else if (ext_clk_en) begin
					sample_now = clk_edge;
				end else begin
					sample_now = rate_tick;
				end
			end
			acms_pkg::ACMS_WAKE: sample_now = wake_tick;
			acms_pkg::ACMS_STBY: sample_now = 1'b0;
			default: sample_now = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_sample_strobe <= 1'b0;
		end else begin
			o_sample_strobe <= sample_now;
		end
	end

	// ---------------- Events ----------------
	assign motion_hit = sample_now && i_motion_detected;
	assign wake_hit = motion_hit && (mode == acms_pkg::ACMS_WAKE);

	// Set wins over clear; no sample in standby, so nothing new is raised there
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			evt_flag <= 1'b0;
		end else if (motion_hit && int_en) begin
			evt_flag <= 1'b1;
		end else if (flag_clr) begin
			evt_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			awake <= 1'b0;
		end else if (wake_hit && awake_en) begin
			awake <= 1'b1;
		end else if (awake_clr) begin
			awake <= 1'b0;
		end
	end

	// ---------------- Outputs ----------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_event_out_a_ext_clock_in_drv <= 1'b0;
			o_event_out_a_ext_clock_in_oe_n <= 1'b0;
			o_event_out_b_sync_trigger_in_drv <= 1'b0;
			o_event_out_b_sync_trigger_in_oe_n <= 1'b0;
			o_awake <= 1'b0;
		end else begin
			o_event_out_a_ext_clock_in_drv <= evt_flag;
			o_event_out_a_ext_clock_in_oe_n <= ext_clk_en;
			o_event_out_b_sync_trigger_in_drv <= evt_flag;
			o_event_out_b_sync_trigger_in_oe_n <= ext_trig_en;
			o_awake <= awake;
		end
	end

	assign o_mode = mode;
	assign o_data_path_en = (mode != acms_pkg::ACMS_STBY);
	// Activity timer runs only in measurement mode
	assign o_activity_timer_en = (mode == acms_pkg::ACMS_MEAS);
	assign o_range = range;
	assign o_output_sample_rate = rate_eff;
	assign o_filter_pole_half_rate_sel = pole_half;
	assign o_filter_pole_div = pole_half ? `ACMS_POLE_DIV_HALF : `ACMS_POLE_DIV_QUARTER;

	// Fixed 12-bit code, so one count weighs more on wider ranges
	always_comb begin
		unique case (range)
			`ACMS_RANGE_2G: o_lsb_weight_mg = `ACMS_WEIGHT_2G;
			`ACMS_RANGE_4G: o_lsb_weight_mg = `ACMS_WEIGHT_4G;
			default: o_lsb_weight_mg = `ACMS_WEIGHT_8G;
		endcase
	end

	// ---------------- Checks ----------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	sequence s_wake_motion;
		(mode == acms_pkg::ACMS_WAKE) && sample_now && i_motion_detected && auto_measure && !wr_mode;
	endsequence

	sequence s_cfg_write;
		wr_cfg;
	endsequence

	sequence s_mode_write;
		wr_mode;
	endsequence

	AST_RESET_STBY: assert property (disable iff (1'b0) i_reset |=> mode == acms_pkg::ACMS_STBY && !o_data_path_en)
		else $error("Mode not standby after reset");
	AST_RESET_QUARTER: assert property (disable iff (1'b0) i_reset |=> o_filter_pole_div == 3'h4)
		else $error("Filter pole not quarter after reset");
	AST_NO_SAMPLE_STBY: assert property (mode == acms_pkg::ACMS_STBY |=> !o_sample_strobe)
		else $error("Sample taken in standby");
	AST_STBY_NO_NEW_FLAG: assert property ((mode == acms_pkg::ACMS_STBY) && !evt_flag |=> !evt_flag)
		else $error("New event raised in standby");
	AST_STBY_KEEP_FLAG: assert property ((mode == acms_pkg::ACMS_STBY) && evt_flag && !flag_clr |=> evt_flag)
		else $error("Pending event lost in standby");
	AST_AUTO_MEASURE: assert property (s_wake_motion |=> mode == acms_pkg::ACMS_MEAS ##1 o_mode == 2'h2)
		else $error("Wake motion did not enter measurement");
	AST_WAKE_SPACING: assert property ((mode == acms_pkg::ACMS_WAKE) && sample_now && !wr_mode |=> !sample_now [*8])
		else $error("Wake samples too close");
	AST_CFG_APPLY: assert property (s_cfg_write |=> o_filter_pole_half_rate_sel == $past(lk_data[3])
		&& o_range == $past(lk_data[5:4]))
		else $error("Configuration write not applied");
	AST_MODE_APPLY: assert property (s_mode_write ##0 (lk_data[1:0] == 2'h1) |=> !o_activity_timer_en && o_data_path_en)
		else $error("Wake-up write did not give wake-up mode");
	AST_WEIGHT_8G: assert property (s_cfg_write ##0 (lk_data[5:4] == 2'h2) |=> o_lsb_weight_mg == 4'h4)
		else $error("Eight g weight wrong");
endmodule // acms_seq

// ==== rtl/acms_cfg.svh ====
`ifndef ACMS_CFG_SVH
`define ACMS_CFG_SVH

// Register addresses on the serial link
`define ACMS_ADDR_MODE 7'h00
`define ACMS_ADDR_CFG 7'h01
`define ACMS_ADDR_WAKE 7'h02
`define ACMS_ADDR_STATUS 7'h03

// Mode register fields
`define ACMS_MODE_LSB 0
`define ACMS_MODE_MSB 1

// Configuration register fields
`define ACMS_RATE_LSB 0
`define ACMS_RATE_MSB 2
`define ACMS_HALF_BIT 3
`define ACMS_RANGE_LSB 4
`define ACMS_RANGE_MSB 5
`define ACMS_EXTCLK_BIT 6
`define ACMS_EXTTRIG_BIT 7

// Wake configuration register fields
`define ACMS_AUTO_BIT 0
`define ACMS_INTEN_BIT 1
`define ACMS_AWEN_BIT 2

// Status register fields
`define ACMS_EVT_BIT 2
`define ACMS_AWAKE_BIT 3

// Reset values
`define ACMS_RATE_RST 3'h3
`define ACMS_HALF_RST 1'h0
`define ACMS_RANGE_RST 2'h0
`define ACMS_WAKE_RST 3'h0

// Rate codes and range weights
`define ACMS_RATE_MAX 3'h5
`define ACMS_RANGE_2G 2'h0
`define ACMS_RANGE_4G 2'h1
`define ACMS_WEIGHT_2G 4'h1
`define ACMS_WEIGHT_4G 4'h2
`define ACMS_WEIGHT_8G 4'h4
`define ACMS_POLE_DIV_HALF 3'h2
`define ACMS_POLE_DIV_QUARTER 3'h4

// Timing: slowest sample period (12.5 Hz) and wake-up period (about 6 per second)
`define ACMS_CLK_MHZ 20
`define ACMS_RATE_MIN_PERIOD_US 80000
`define ACMS_WAKE_PERIOD_US 160000
`define ACMS_RATE_BASE_CYC (`ACMS_RATE_MIN_PERIOD_US * `ACMS_CLK_MHZ)
`define ACMS_WAKE_CYC (`ACMS_WAKE_PERIOD_US * `ACMS_CLK_MHZ)

`endif

// ==== rtl/acms_pkg.sv ====
package acms_pkg;
	typedef enum logic [1:0] {
		ACMS_STBY = 2'b00,
		ACMS_WAKE = 2'b01,
		ACMS_MEAS = 2'b10
	} acms_mode_t;
endpackage

// ==== rtl/acms_sync.sv ====
`timescale 1ns/100ps
module acms_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk) begin
				if (i_reset) begin
					meta[g] <= 1'b0;
					o_q[g] <= 1'b0;
				end else begin
					meta[g] <= i_d[g];
					o_q[g] <= meta[g];
				end
			end
		end
	endgenerate
endmodule // acms_sync

// ==== sim/acms_host.sv ====
`timescale 1ns/100ps
module acms_host (
	// Serial link to the device
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_mosi,
	input wire logic i_miso
);
	initial begin
		o_sclk = 1'b0;
		o_mosi = 1'b0;
		// Deselect after time zero so the frame's asynchronous clear sees an edge
		#1 o_cs_n = 1'b1;
	end

	// Mode 0, MSB first; clock stands low between frames
	task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
		rd = 8'h00;
		o_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			o_mosi = f[i];
			#6 o_sclk = 1'b1;
			if (i < 8)
				rd[i] = i_miso;
			#6 o_sclk = 1'b0;
		end
		#6 o_cs_n = 1'b1;
		// Released line must not keep showing the last bit
		o_mosi = ~o_mosi;
	endtask
endmodule // acms_host

// ==== sim/accel_mode_sequencer_test.sv ====
`timescale 1ns/100ps
`include "acms_cfg.svh"
module accel_mode_sequencer_test;
	logic i_clk, i_reset, sclk, cs_n, mosi, miso, miso_oe_n;
	logic pa, pb, a_drv, a_oe_n, b_drv, b_oe_n, motion, strobe, half, dpe, ate, awake;
	logic [1:0] mode, range;
	logic [3:0] weight;
	logic [2:0] rate, div;
	int miscompares = 0;
	int num_checks = 0;

	acms_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));

	// Short counts keep the run brief
	acms_seq #(.P_RATE_BASE_CYC(640), .P_WAKE_CYC(40)) uut (
		.i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
		.o_miso(miso), .o_miso_oe_n(miso_oe_n),
		.i_event_out_a_ext_clock_in(pa), .o_event_out_a_ext_clock_in_drv(a_drv),
		.o_event_out_a_ext_clock_in_oe_n(a_oe_n),
		.i_event_out_b_sync_trigger_in(pb), .o_event_out_b_sync_trigger_in_drv(b_drv),
		.o_event_out_b_sync_trigger_in_oe_n(b_oe_n),
		.i_motion_detected(motion), .o_sample_strobe(strobe), .o_mode(mode),
		.o_data_path_en(dpe), .o_activity_timer_en(ate), .o_range(range),
		.o_lsb_weight_mg(weight), .o_output_sample_rate(rate),
		.o_filter_pole_half_rate_sel(half), .o_filter_pole_div(div), .o_awake(awake));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_cnt(input string what, input int exp, input int got);
		num_checks++;
		if (got != exp) begin
			miscompares++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// Write lands a few system cycles after the last edge
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		host.xfer({1'b1, a, d}, r);
		repeat (6) @(negedge i_clk);
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		host.xfer({1'b0, a, 8'h00}, d);
		@(negedge i_clk);
	endtask

	// Counts strobes; pin 1 or 2 pulses that pin every ten cycles
	task automatic count(input int n, input int pin, output int c);
		c = 0;
		for (int k = 0; k < n; k++) begin
			@(negedge i_clk);
			if (pin == 1)
				pa = (k % 10) < 5;
			if (pin == 2)
				pb = (k % 10) < 5;
			if (strobe === 1'b1)
				c++;
		end
	endtask

	task automatic t_reset;
		int c;
		check_val("mode", 8'h00, mode);
		check_val("data path", 8'h00, dpe);
		check_val("half sel", 8'h00, half);
		check_val("pole div", 8'h04, div);
		check_val("miso oe_n", 8'h01, miso_oe_n);
		count(100, 0, c);
		check_cnt("standby strobes", 0, c);
		$display("test reset done");
	endtask

	task automatic t_cfg;
		logic [7:0] d;
		for (int r = 0; r < 3; r++) begin
			wr(`ACMS_ADDR_CFG, {2'b00, r[1:0], 4'h0});
			check_val("range", r[7:0], range);
			check_val("weight", 8'h01 << r, weight);
		end
		wr(`ACMS_ADDR_CFG, 8'h0D);
		check_val("rate", 8'h05, rate);
		check_val("pole div", 8'h02, div);
		check_val("half sel", 8'h01, half);
		rd(`ACMS_ADDR_CFG, d);
		check_val("cfg readback", 8'h0D, d);
		wr(`ACMS_ADDR_CFG, 8'h00);
		check_val("rate", 8'h00, rate);
		check_val("pole div", 8'h04, div);
		wr(`ACMS_ADDR_CFG, 8'h07);
		check_val("rate clamp", 8'h05, rate);
		wr(`ACMS_ADDR_CFG, 8'h05);
		$display("test config done");
	endtask

	task automatic t_meas;
		int c;
		wr(`ACMS_ADDR_MODE, acms_pkg::ACMS_MEAS);
		check_val("mode", 8'h02, mode);
		check_val("data path", 8'h01, dpe);
		check_val("timer en", 8'h01, ate);
		count(200, 0, c);
		check_cnt("fast strobes", 10, c);
		$display("test measure done");
	endtask

	task automatic t_wake;
		int c;
		logic [7:0] d;
		wr(`ACMS_ADDR_WAKE, 8'h07);
		wr(`ACMS_ADDR_MODE, acms_pkg::ACMS_WAKE);
		check_val("timer en", 8'h00, ate);
		check_val("data path", 8'h01, dpe);
		count(400, 0, c);
		check_cnt("wake strobes", 10, c);
		rd(`ACMS_ADDR_CFG, d);
		check_val("cfg in wake", 8'h05, d);
		motion = 1'b1;
		for (int k = 0; k < 100 && mode !== 2'b10; k++)
			@(negedge i_clk);
		repeat (2) @(negedge i_clk);
		check_val("auto mode", 8'h02, mode);
		check_val("awake", 8'h01, awake);
		check_val("pin a", 8'h01, a_drv);
		check_val("pin a oe_n", 8'h00, a_oe_n);
		rd(`ACMS_ADDR_STATUS, d);
		check_val("status", 8'h0E, d);
		$display("test wake done");
	endtask

	task automatic t_stby;
		int c;
		// Code 3 is decoded as standby as well
		wr(`ACMS_ADDR_MODE, 8'h03);
		check_val("mode", 8'h00, mode);
		count(100, 0, c);
		check_cnt("standby strobes", 0, c);
		check_val("kept flag", 8'h01, a_drv);
		wr(`ACMS_ADDR_STATUS, 8'h0C);
		count(100, 0, c);
		check_val("no new flag", 8'h00, b_drv);
		check_val("awake", 8'h00, awake);
		motion = 1'b0;
		$display("test standby done");
	endtask

	task automatic t_ext;
		int c;
		wr(`ACMS_ADDR_CFG, 8'h45);
		wr(`ACMS_ADDR_MODE, acms_pkg::ACMS_MEAS);
		check_val("pin a oe_n", 8'h01, a_oe_n);
		count(100, 1, c);
		check_cnt("clock strobes", 10, c);
		wr(`ACMS_ADDR_CFG, 8'hC5);
		check_val("pin b oe_n", 8'h01, b_oe_n);
		count(100, 2, c);
		check_cnt("trigger strobes", 10, c);
		wr(`ACMS_ADDR_MODE, acms_pkg::ACMS_STBY);
		check_val("mode", 8'h00, mode);
		$display("test external done");
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		pa = 1'b0;
		pb = 1'b0;
		motion = 1'b0;
		// Raised after time zero so the link's asynchronous reset sees an edge
		#1 i_reset = 1'b1;
		repeat (10) @(negedge i_clk);
		i_reset = 1'b0;
		@(negedge i_clk);
		t_reset();
		t_cfg();
		t_meas();
		t_wake();
		t_stby();
		t_ext();
		finish_test();
	end

	// Tests need under two thousand cycles; this allows far more
	initial begin
		#2000000;
		miscompares++;
		finish_test();
	end
endmodule // accel_mode_sequencer_test
